// File: bench/spi_master_model.sv
// Behavioural serial bus master that drives the flash front end
module spi_master_model (
  // Serial link
  output logic spi_clk_out,
  output logic cs_b_out,
  output logic d_out,
  output logic hold_b_out,
  // Data back from the memory
  input  logic q_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        cpol;
  logic [63:0] rx;
  initial begin
    rx          = 64'h0;
    cpol        = 1'b0;
    spi_clk_out = 1'b0;
    cs_b_out    = 1'b1;
    d_out       = 1'b0;
    hold_b_out  = 1'b1;
  end
  // Clock parks at its polarity before the select edge
  task automatic select(input logic pol);
    cpol        = pol;
    spi_clk_out = pol;
    #40;
    cs_b_out = 1'b0;
    #15;
  endtask
  // Data changes while the clock is low, sampled on the rise
  task automatic shift(input logic [63:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      spi_clk_out = 1'b0;
      d_out       = bits[63-i];
      #15;
      rx          = {rx[62:0], q_in};
      spi_clk_out = 1'b1;
      #15;
    end
  endtask
  // Released data line shows the inverse of its last value
  task automatic deselect();
    spi_clk_out = cpol;
    #15;
    cs_b_out = 1'b1;
    d_out    = ~d_out;
  endtask
  task automatic set_hold(input logic v);
    hold_b_out = v;
    #15;
  endtask
  task automatic set_clk(input logic v);
    spi_clk_out = v;
    #15;
  endtask
endmodule // spi_master_model

// File: bench/test_serial_flash_spi_interface.sv
// Self-checking testbench of the serial flash interface front end
module test_serial_flash_spi_interface
  import flash_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys_in;
  logic       rst_b_in;
  logic       spi_clk_in;
  logic       cs_b_in;
  logic       d_in;
  logic       hold_b_in;
  logic       wp_b_in;
  logic       q_out;
  logic       q_oe_b_out;
  logic [2:0] block_protect_bits_in;
  logic       busy_in;
  cmd_t       cmd_out;
  logic       cmd_valid_out;
  logic       refused_out;
  logic       standby_out;
  logic       hold_active_out;
  int         miscompares;
  int         compares;
  logic       ok;
  logic       rej;

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  spi_master_model u_mst (
    .spi_clk_out (spi_clk_in),
    .cs_b_out    (cs_b_in),
    .d_out       (d_in),
    .hold_b_out  (hold_b_in),
    .q_in        (q_out)
  );

  serial_flash_spi_interface u_dut (
    .clk_sys_in            (clk_sys_in),
    .rst_b_in              (rst_b_in),
    .spi_clk_in            (spi_clk_in),
    .cs_b_in               (cs_b_in),
    .d_in                  (d_in),
    .hold_b_in             (hold_b_in),
    .wp_b_in               (wp_b_in),
    .q_out                 (q_out),
    .q_oe_b_out            (q_oe_b_out),
    .block_protect_bits_in (block_protect_bits_in),
    .busy_in               (busy_in),
    .cmd_out               (cmd_out),
    .cmd_valid_out         (cmd_valid_out),
    .refused_out           (refused_out),
    .standby_out           (standby_out),
    .hold_active_out       (hold_active_out)
  );

  task automatic chk_val(input logic [35:0] got, input logic [35:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic sys(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // Pulses last one cycle, so every cycle of the window is looked at
  task automatic frame(input logic pol, input logic [63:0] bits, input int n);
    u_mst.select(pol);
    u_mst.shift(bits, n);
    u_mst.deselect();
    ok  = 1'b0;
    rej = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk_sys_in);
      if (cmd_valid_out === 1'b1) ok = 1'b1;
      if (refused_out === 1'b1) rej = 1'b1;
    end
  endtask

  task automatic t_program();
    frame(1'b0, {8'h10, 6'h05, 10'h3FF, 8'hFE, 16'hA55A, 16'h0}, 33);
    chk_val(36'(rej), 36'h1, "unaligned frame not refused");
    frame(1'b0, {8'h10, 6'h05, 10'h3FF, 8'hFE, 16'hA55A, 16'h0}, 48);
    chk_val(36'({ok, rej}), 36'h2, "program not accepted");
    chk_val(cmd_out, {CMD_PROGRAM, 6'h05, 10'h3FF, 8'hFE, 9'h002}, "program fields");
    $display("test program done");
  endtask

  task automatic t_mode3();
    frame(1'b1, {8'h20, 6'h3F, 10'h001, 8'h00, 32'h0}, 32);
    chk_val(36'({ok, rej}), 36'h2, "mode 3 erase not accepted");
    chk_val(36'({cmd_out.kind, cmd_out.addr}), {9'h0, CMD_SECTOR_ERASE, 24'hFC0100}, "erase fields");
    $display("test mode3 done");
  endtask

  task automatic t_protect();
    block_protect_bits_in = 3'h1;
    sys(10);
    wp_b_in = 1'b0;
    sys(10);
    block_protect_bits_in = 3'h0;
    frame(1'b0, {8'h20, 6'h3F, 18'h0, 32'h0}, 32);
    chk_val(36'({ok, rej}), 36'h1, "top sector erase not refused");
    frame(1'b0, {8'h20, 6'h3E, 18'h0, 32'h0}, 32);
    chk_val(36'({ok, rej}), 36'h2, "lower sector erase refused");
    frame(1'b0, {8'h30, 56'h0}, 8);
    chk_val(36'({ok, rej}), 36'h1, "bulk erase not refused");
    frame(1'b0, {8'h40, 56'h0}, 16);
    chk_val(36'({ok, rej}), 36'h1, "status write not refused");
    wp_b_in = 1'b1;
    sys(10);
    frame(1'b0, {8'h30, 56'h0}, 8);
    chk_val(36'({ok, rej}), 36'h2, "bulk erase refused");
    chk_val(36'(cmd_out.kind), 36'(CMD_BULK_ERASE), "bulk erase kind");
    frame(1'b0, {8'h40, 56'h0}, 16);
    chk_val(36'({ok, rej}), 36'h2, "status write refused");
    $display("test protect done");
  endtask

  // Protect settings 1 to 7: lowest protected sector refused, the one below accepted where one exists
  task automatic t_areas();
    int first;
    for (int k = 1; k < 8; k++) begin
      block_protect_bits_in = 3'(k);
      first = 64 - (1 << (k - 1));
      sys(4);
      frame(1'b0, {8'h20, 6'(first), 50'h0}, 32);
      chk_val(36'({ok, rej}), 36'h1, "protected sector erase not refused");
      if (first > 0) begin
        frame(1'b0, {8'h20, 6'(first - 1), 50'h0}, 32);
        chk_val(36'({ok, rej}), 36'h2, "open sector erase refused");
      end
    end
    block_protect_bits_in = 3'h0;
    sys(4);
    $display("test areas done");
  endtask

  // Reads back the two bytes that the program test left at the page end
  task automatic t_read();
    frame(1'b0, {8'h50, 6'h05, 10'h3FF, 8'hFE, 32'h0}, 48);
    chk_val(36'({ok, rej}), 36'h0, "read gave a writing answer");
    chk_val(36'(u_mst.rx[15:0]), 36'hA55A, "read data");
    frame(1'b1, {8'h50, 24'h0000FE, 32'h0}, 48);
    chk_val(36'(u_mst.rx[15:0]), 36'hA55A, "mode 3 read data");
    $display("test read done");
  endtask

  task automatic t_standby();
    chk_val(36'({standby_out, q_oe_b_out}), 36'h3, "idle not standby");
    u_mst.select(1'b0);
    sys(10);
    chk_val(36'({standby_out, q_oe_b_out}), 36'h0, "selected not active");
    u_mst.deselect();
    sys(1);
    busy_in = 1'b1;
    sys(10);
    chk_val(36'({standby_out, q_oe_b_out}), 36'h1, "standby while busy");
    frame(1'b0, {8'h10, 24'h0, 8'h11, 24'h0}, 40);
    chk_val(36'({ok, rej}), 36'h1, "busy program not refused");
    busy_in = 1'b0;
    $display("test standby done");
  endtask

  task automatic t_hold();
    u_mst.select(1'b0);
    u_mst.set_hold(1'b0);
    u_mst.set_clk(1'b1);
    u_mst.set_clk(1'b0);
    sys(10);
    chk_val(36'({hold_active_out, q_oe_b_out}), 36'h3, "hold not entered");
    u_mst.set_hold(1'b1);
    sys(10);
    chk_val(36'({hold_active_out, q_oe_b_out}), 36'h0, "hold not left");
    u_mst.set_clk(1'b1);
    u_mst.set_clk(1'b0);
    u_mst.deselect();
    u_mst.select(1'b1);
    u_mst.set_hold(1'b0);
    sys(10);
    chk_val(36'(hold_active_out), 36'h0, "hold began with clock high");
    u_mst.set_clk(1'b0);
    sys(10);
    chk_val(36'({hold_active_out, q_oe_b_out}), 36'h3, "hold missed clock low");
    u_mst.set_hold(1'b1);
    sys(10);
    chk_val(36'(hold_active_out), 36'h0, "hold stuck");
    u_mst.deselect();
    sys(10);
    chk_val(36'(q_oe_b_out), 36'h1, "output driven when deselected");
    $display("test hold done");
  endtask

  initial begin
    miscompares           = 0;
    compares              = 0;
    rst_b_in              = 1'b0;
    wp_b_in               = 1'b1;
    busy_in               = 1'b0;
    block_protect_bits_in = 3'h0;
    repeat (10) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    sys(6);
    t_standby();
    t_program();
    t_read();
    t_mode3();
    t_protect();
    t_areas();
    t_hold();
    finish_test();
  end
endmodule // test_serial_flash_spi_interface

// File: common/flash_spi_map.svh
// Constants of the serial flash interface front end
`ifndef FLASH_SPI_MAP_SVH
`define FLASH_SPI_MAP_SVH

`define FS_SECTORS          64
`define FS_PAGES_PER_SECTOR 1024
`define FS_PAGE_BYTES       256
`define FS_SECTOR_W         6
`define FS_PAGE_W           10
`define FS_COL_W            8
`define FS_COUNT_W          9
`define FS_BP_W             3
`define FS_BP_RESET         3'h0
`define FS_BYTE_BITS        8
`define FS_LAST_BIT         3'h7
`define FS_ADDR_BYTES       3
`define FS_LAST_ADDR_IDX    2'h2
`define FS_SYNC_W           5
`define FS_OP_PROGRAM       8'h10
`define FS_OP_SECTOR_ERASE  8'h20
`define FS_OP_BULK_ERASE    8'h30
`define FS_OP_STATUS_WRITE  8'h40
`define FS_OP_READ          8'h50

`endif

// File: common/flash_spi_pkg.sv
// Types shared by the serial flash interface front end
package flash_spi_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_PROGRAM,
    CMD_SECTOR_ERASE,
    CMD_BULK_ERASE,
    CMD_STATUS_WRITE
  } cmd_kind_t;

  typedef enum logic [1:0] {
    PH_OP,
    PH_ADDR,
    PH_DATA
  } link_phase_t;

  typedef struct packed {
    logic [5:0] sector;
    logic [9:0] page;
    logic [7:0] column;
  } flash_addr_t;

  typedef struct packed {
    cmd_kind_t   kind;
    flash_addr_t addr;
    logic [8:0]  nbytes;
  } cmd_t;

endpackage

// File: src/page_buffer_mem.sv
// Page data buffer with registered read data
module page_buffer_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  // Clock
  input  wire logic          clk_in,
  // Access
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [7:0]    wr_data_in,
  output logic      [7:0]    rd_data_out
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rd_data_out <= mem[addr_in];
  end

endmodule // page_buffer_mem

// File: src/serial_flash_spi_interface.sv
// Serial interface front end of a serial flash memory
`include "flash_spi_map.svh"

module serial_flash_spi_interface
  import flash_spi_pkg::*;
#(
  parameter logic [7:0] OP_PROGRAM      = `FS_OP_PROGRAM,
  parameter logic [7:0] OP_SECTOR_ERASE = `FS_OP_SECTOR_ERASE,
  parameter logic [7:0] OP_BULK_ERASE   = `FS_OP_BULK_ERASE,
  parameter logic [7:0] OP_STATUS_WRITE = `FS_OP_STATUS_WRITE,
  parameter logic [7:0] OP_READ         = `FS_OP_READ
) (
  // System clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_b_in,
  // Serial link from the bus master
  input  wire logic             spi_clk_in,
  input  wire logic             cs_b_in,
  input  wire logic             d_in,
  input  wire logic             hold_b_in,
  input  wire logic             wp_b_in,
  // Serial data output pin
  output logic                  q_out,
  output logic                  q_oe_b_out,
  // Memory core side
  input  wire logic [2:0]       block_protect_bits_in,
  input  wire logic             busy_in,
  output cmd_t                  cmd_out,
  output logic                  cmd_valid_out,
  output logic                  refused_out,
  // Status
  output logic                  standby_out,
  output logic                  hold_active_out
);

  // Link domain state
  logic [2:0]        bit_cnt;
  logic [7:0]        rx_sr;
  link_phase_t       phase;
  logic [1:0]        addr_idx;
  logic [7:0]        col_ptr;
  logic [7:0]        tx_sr;
  logic [7:0]        mem_rdata;
  logic [7:0]        frame_op;
  flash_addr_t       frame_addr;
  logic [8:0]        frame_nbytes;
  logic              frame_aligned;
  logic              frame_tgl;
  logic [7:0]        next_rx;
  logic              byte_done;
  logic              mem_we;
  logic [7:0]        mem_addr;

  // System domain state
  logic [4:0]        sync1;
  logic [4:0]        sync2;
  logic              cs_s;
  logic              hold_s;
  logic              sclk_s;
  logic              wp_s;
  logic              tgl_s;
  logic              cs_prev;
  logic              armed;
  logic              start_tgl;
  logic              hold_active;
  logic              next_hold_active;
  logic [2:0]        bp_eff;
  cmd_kind_t         kind;
  logic              prot;
  logic              frame_end;

  assign next_rx   = {rx_sr[6:0], d_in};
  assign byte_done = (bit_cnt == `FS_LAST_BIT);
  assign mem_we    = byte_done && (phase == PH_DATA) && (frame_op == OP_PROGRAM);
  assign mem_addr  = mem_we ? col_ptr :
                     (phase == PH_ADDR) ? next_rx : 8'(col_ptr + 8'h01);

  // Bit counter and instruction phase, cleared by deselect
  always_ff @(posedge spi_clk_in or posedge cs_b_in or negedge rst_b_in) begin
    if (!rst_b_in || cs_b_in) begin
      bit_cnt  <= 3'h0;
      rx_sr    <= 8'h00;
      phase    <= PH_OP;
      addr_idx <= 2'h0;
      col_ptr  <= 8'h00;
    end else if (hold_b_in) begin
      bit_cnt <= 3'(bit_cnt + 3'h1);
      rx_sr   <= next_rx;
      if (byte_done) begin
        unique case (phase)
          PH_OP: begin
            phase <= PH_ADDR;
          end
          PH_ADDR: begin
            addr_idx <= 2'(addr_idx + 2'h1);
            if (addr_idx == `FS_LAST_ADDR_IDX) begin
              phase   <= PH_DATA;
              col_ptr <= next_rx;
            end
          end
          PH_DATA: begin
            col_ptr <= 8'(col_ptr + 8'h01);
          end
        endcase
      end
    end
  end

  // Frame summary kept past deselect for the system side
  always_ff @(posedge spi_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      frame_op      <= 8'h00;
      frame_addr    <= '0;
      frame_nbytes  <= 9'h000;
      frame_aligned <= 1'b0;
      frame_tgl     <= 1'b0;
    end else if (!cs_b_in && hold_b_in) begin
      frame_aligned <= byte_done;
      if (byte_done) begin
        unique case (phase)
          PH_OP: begin
            frame_op     <= next_rx;
            frame_nbytes <= 9'h000;
            frame_tgl    <= ~frame_tgl;
          end
          PH_ADDR: begin
            unique case (addr_idx)
              2'h0: frame_addr[23:16] <= next_rx;
              2'h1: frame_addr[15:8]  <= next_rx;
              default: frame_addr[7:0] <= next_rx;
            endcase
          end
          PH_DATA: begin
            if (frame_nbytes != 9'(`FS_PAGE_BYTES)) begin
              frame_nbytes <= 9'(frame_nbytes + 9'h001);
            end
          end
        endcase
      end
    end
  end

  page_buffer_mem #(
    .DEPTH (`FS_PAGE_BYTES),
    .AW    (`FS_COL_W)
  ) u_page_buffer (
    .clk_in      (spi_clk_in),
    .wr_en_in    (mem_we && !cs_b_in && hold_b_in),
    .addr_in     (mem_addr),
    .wr_data_in  (next_rx),
    .rd_data_out (mem_rdata)
  );

  // Output shifter driven from falling edges
  always_ff @(negedge spi_clk_in or posedge cs_b_in or negedge rst_b_in) begin
    if (!rst_b_in || cs_b_in) begin
      tx_sr <= 8'h00;
    end else if (hold_b_in) begin
      if (bit_cnt == 3'h0 && phase == PH_DATA && frame_op == OP_READ) begin
        tx_sr <= mem_rdata;
      end else begin
        tx_sr <= {tx_sr[6:0], 1'b0};
      end
    end
  end

  assign q_out = tx_sr[7];

  // Two-stage synchronisers for pins and the frame toggle
  genvar gi;
  generate
    for (gi = 0; gi < `FS_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else begin
          sync1[gi] <= (gi == 0) ? cs_b_in : (gi == 1) ? hold_b_in :
                       (gi == 2) ? spi_clk_in : (gi == 3) ? wp_b_in : frame_tgl;
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign cs_s      = sync2[0];
  assign hold_s    = sync2[1];
  assign sclk_s    = sync2[2];
  assign wp_s      = sync2[3];
  assign tgl_s     = sync2[4];
  assign frame_end = cs_s && !cs_prev;

  // Pause follows the pin only while the clock is low and selected
  always_comb begin
    next_hold_active = hold_active;
    if (cs_s) begin
      next_hold_active = 1'b0;
    end else if (!sclk_s) begin
      next_hold_active = !hold_s;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_active     <= 1'b0;
      hold_active_out <= 1'b0;
      q_oe_b_out      <= 1'b1;
    end else begin
      hold_active     <= next_hold_active;
      hold_active_out <= next_hold_active;
      q_oe_b_out      <= cs_s || next_hold_active;
    end
  end

  // Standby only when deselected and idle; pause does not touch busy
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      standby_out <= 1'b0;
    end else begin
      standby_out <= cs_s && !busy_in;
    end
  end

  // Select edge tracking since reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cs_prev   <= 1'b1;
      armed     <= 1'b0;
      start_tgl <= 1'b0;
    end else begin
      cs_prev <= cs_s;
      if (!cs_s && cs_prev) begin
        armed     <= 1'b1;
        start_tgl <= tgl_s;
      end
    end
  end

  // Protect bits follow the core only while write-protect is high
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bp_eff <= `FS_BP_RESET;
    end else if (wp_s) begin
      bp_eff <= block_protect_bits_in;
    end
  end

  function automatic logic sector_protected(input logic [2:0] bp, input logic [5:0] sector);
    logic [6:0] first;
    first = 7'(`FS_SECTORS) - 7'(7'h01 << (bp - 3'h1));
    return (bp != 3'h0) && ({1'b0, sector} >= first);
  endfunction

  always_comb begin
    kind = CMD_NONE;
    if (frame_op == OP_PROGRAM) begin
      kind = CMD_PROGRAM;
    end else if (frame_op == OP_SECTOR_ERASE) begin
      kind = CMD_SECTOR_ERASE;
    end else if (frame_op == OP_BULK_ERASE) begin
      kind = CMD_BULK_ERASE;
    end else if (frame_op == OP_STATUS_WRITE) begin
      kind = CMD_STATUS_WRITE;
    end
  end

  always_comb begin
    unique case (kind)
      CMD_PROGRAM:      prot = sector_protected(bp_eff, frame_addr.sector) || (frame_nbytes == 9'h000);
      CMD_SECTOR_ERASE: prot = sector_protected(bp_eff, frame_addr.sector);
      CMD_BULK_ERASE:   prot = (bp_eff != 3'h0);
      CMD_STATUS_WRITE: prot = !wp_s;
      default:          prot = 1'b0;
    endcase
  end

  // Issue or refuse the writing instruction at deselect
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_valid_out <= 1'b0;
      refused_out   <= 1'b0;
      cmd_out       <= '0;
    end else begin
      cmd_valid_out <= 1'b0;
      refused_out   <= 1'b0;
      if (frame_end && armed && tgl_s != start_tgl && kind != CMD_NONE) begin
        if (frame_aligned && !prot && !busy_in) begin
          cmd_valid_out <= 1'b1;
          cmd_out       <= '{kind: kind, addr: frame_addr, nbytes: frame_nbytes};
        end else begin
          refused_out <= 1'b1;
        end
      end
    end
  end

  standby_busy_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    busy_in |=> !standby_out) else $error("standby while busy");
  deselect_hiz_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cs_s |=> q_oe_b_out) else $error("output driven while deselected");
  hold_hiz_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    hold_active |-> q_oe_b_out) else $error("output driven during pause");
  hold_freeze_a: assert property (@(posedge spi_clk_in) disable iff (cs_b_in || !rst_b_in)
    !hold_b_in |=> $stable(bit_cnt) && $stable(rx_sr)) else $error("link moved during pause");
  hold_clock_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    $changed(hold_active) && !cs_s |-> !$past(sclk_s)) else $error("pause changed with clock high");
  unarmed_ignore_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !armed |=> !cmd_valid_out && !refused_out) else $error("instruction before select edge");
  aligned_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cmd_valid_out |-> frame_aligned) else $error("unaligned instruction executed");
  bulk_protect_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cmd_valid_out && cmd_out.kind == CMD_BULK_ERASE |-> bp_eff == 3'h0) else $error("bulk erase while protected");
  freeze_bits_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !$past(wp_s) |-> bp_eff == $past(bp_eff)) else $error("protect bits moved while frozen");
  page_count_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    cmd_valid_out && cmd_out.kind == CMD_PROGRAM |-> cmd_out.nbytes inside {[1:256]})
    else $error("page program byte count out of range");
  sample_rise_a: assert property (@(posedge spi_clk_in) disable iff (cs_b_in || !rst_b_in)
    hold_b_in ##1 (hold_b_in && bit_cnt != 3'h0) |-> rx_sr[0] == $past(d_in)) else $error("input not sampled");

  program_cov_c: cover property (@(posedge clk_sys_in) cmd_valid_out && cmd_out.kind == CMD_PROGRAM);
  erase_cov_c: cover property (@(posedge clk_sys_in) cmd_valid_out && cmd_out.kind == CMD_SECTOR_ERASE);
  refuse_cov_c: cover property (@(posedge clk_sys_in) refused_out);
  hold_cov_c: cover property (@(posedge clk_sys_in) $rose(hold_active));

endmodule // serial_flash_spi_interface
